// ===== hdl/dac_dev.sv
// device end: frame receiver, code register and power-down mode control
// Contract
// RQ1: frame opens on falling frame line
// RQ2: shift data on falling clock edges
// RQ3: sixteenth falling edge applies the frame
// RQ4: host raises frame line before next
// RQ5: msb first, mode at bits 13:12
// RQ6: code at bits 11:4, rest ignored
// RQ7: byte hosts keep frame low across two
// RQ8: early frame rise discards the frame
// RQ9: power-up code register is zero
// RQ10: mode decode: normal, 1k, 100k, hiz
// RQ11: nonzero mode shuts bias, applies termination
// RQ12: power-down keeps code, output returns
// RQ13: code straight binary zero to 255
// RQ14: host idles lines low between frames
// RQ15: spi master uses polarity 0 phase 1
// RQ16: three-wire host changes data on rise
// RQ17: edges after sixteenth ignored until reframe
`timescale 1ns/1ps
module dac_dev (
   input wire logic sys_clk,
   input wire logic rst_n,
   dac_link_if.dev link,
   output logic [7:0] code,
   output logic [1:0] mode,
   output logic powered,
   output logic term_1k,
   output logic term_100k,
   output logic out_hiz,
   output logic out_enable,
   output logic update
);
   typedef enum logic [1:0] {R_IDLE, R_SHIFT, R_DONE} rx_st_e;
   // edge pins get a third stage for edge detection; bit 0 frame line, bit 1 serial clock
   localparam int EDGE_PINS = 2;
   localparam int FRAME_PIN = 0;
   localparam int CLOCK_PIN = 1;
   // reset each stage to its pin's rest level, so no false edge follows reset
   localparam logic [EDGE_PINS-1:0] PIN_IDLE = 2'h1;
   rx_st_e st_ff, nxt_st;
   logic [EDGE_PINS-1:0] pin_raw, pin_s, pin_d;
   logic [1:0] din_sync_ff, nxt_din_sync;
   logic [dac_link_pkg::FRAME_BITS-1:0] sh_ff, nxt_sh, frame_w;
   logic [4:0] cnt_ff, nxt_cnt;
   logic [dac_link_pkg::CODE_BITS-1:0] code_ff, nxt_code;
   logic [dac_link_pkg::MODE_BITS-1:0] mode_ff, nxt_mode;
   logic upd_ff, nxt_upd;
   logic pwr_ff, t1k_ff, t100k_ff, hiz_ff, oe_ff;
   logic nxt_pwr, nxt_t1k, nxt_t100k, nxt_hiz, nxt_oe;
   logic fr_fall, fr_high, sck_fall, din_s;

   // a fall shows as the older stage high and the newer stage low
   function automatic logic fell(input logic older, input logic newer);
      return older && !newer;
   endfunction

   // mode field of an assembled frame; the two leading bits are never looked at
   function automatic logic [dac_link_pkg::MODE_BITS-1:0] frame_mode(
      input logic [dac_link_pkg::FRAME_BITS-1:0] f);
      return f[dac_link_pkg::MODE_HI_POS:dac_link_pkg::MODE_LO_POS];
   endfunction

   // converter code of an assembled frame; the four trailing bits are dropped
   function automatic logic [dac_link_pkg::CODE_BITS-1:0] frame_code(
      input logic [dac_link_pkg::FRAME_BITS-1:0] f);
      return f[dac_link_pkg::CODE_MSB_POS:dac_link_pkg::CODE_LSB_POS];
   endfunction

   // one-hot view of the mode: normal, 1k pulldown, 100k pulldown, high impedance
   function automatic logic [3:0] mode_onehot(input logic [dac_link_pkg::MODE_BITS-1:0] m);
      logic [3:0] oh;
      oh = 4'h0;
      case (m)
         dac_link_pkg::MODE_NORMAL: oh = 4'h8;
         dac_link_pkg::MODE_PD_1K: oh = 4'h4;
         dac_link_pkg::MODE_PD_100K: oh = 4'h2;
         default: oh = 4'h1;
      endcase
      return oh;
   endfunction

   assign pin_raw = {link.sclk, link.frame_n};

   // only the second stage feeds logic; the third just remembers it for edge detection
   for (genvar g = 0; g < EDGE_PINS; g++) begin : g_edge_sync
      logic [2:0] stg_ff;
      logic [2:0] nxt_stg;
      always_comb begin
         nxt_stg = {stg_ff[1:0], pin_raw[g]};
      end
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            stg_ff <= {3{PIN_IDLE[g]}};
         end else begin
            stg_ff <= nxt_stg;
         end
      end
      assign pin_s[g] = stg_ff[1];
      assign pin_d[g] = stg_ff[2];
   end

   // data needs no edge detection; it is held steady around each clock fall
   always_comb begin
      nxt_din_sync = {din_sync_ff[0], link.din};
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         din_sync_ff <= 2'h0;
      end else begin
         din_sync_ff <= nxt_din_sync;
      end
   end

   assign fr_high = pin_s[FRAME_PIN];
   assign fr_fall = fell(pin_d[FRAME_PIN], pin_s[FRAME_PIN]); // RQ1
   assign sck_fall = fell(pin_d[CLOCK_PIN], pin_s[CLOCK_PIN]); // RQ2
   assign din_s = din_sync_ff[1];
   // the frame as it stands once the current bit is shifted in
   assign frame_w = {sh_ff[dac_link_pkg::FRAME_BITS-2:0], din_s}; // RQ5

   // frame receiver; the clock period must exceed several sys_clk cycles
   always_comb begin
      nxt_st = st_ff;
      nxt_sh = sh_ff;
      nxt_cnt = cnt_ff;
      nxt_code = code_ff;
      nxt_mode = mode_ff;
      nxt_upd = 1'b0;
      case (st_ff)
         R_IDLE: begin
            if (fr_fall) begin
               nxt_st = R_SHIFT; // RQ1
               nxt_cnt = 5'h00;
               nxt_sh = 16'h0000;
            end
         end
         R_SHIFT: begin
            if (fr_high) begin
               nxt_sh = 16'h0000; // RQ8
               nxt_st = R_IDLE; // RQ8
            end else if (sck_fall) begin
               nxt_sh = frame_w; // RQ2 RQ5 RQ7
               nxt_cnt = cnt_ff + 5'h01;
               if (cnt_ff == 5'(dac_link_pkg::FRAME_BITS - 1)) begin
                  // apply at once on the last edge
                  nxt_mode = frame_mode(frame_w); // RQ3 RQ5
                  nxt_code = frame_code(frame_w); // RQ6 RQ12 RQ13
                  nxt_upd = 1'b1; // RQ3
                  nxt_st = R_DONE;
               end
            end
         end
         default: begin
            if (fr_high) begin
               nxt_st = R_IDLE; // RQ17
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_ff <= R_IDLE;
         sh_ff <= 16'h0000;
         cnt_ff <= 5'h00;
         code_ff <= dac_link_pkg::CODE_RESET; // RQ9
         mode_ff <= dac_link_pkg::MODE_NORMAL;
         upd_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         sh_ff <= nxt_sh;
         cnt_ff <= nxt_cnt;
         code_ff <= nxt_code;
         mode_ff <= nxt_mode;
         upd_ff <= nxt_upd;
      end
   end

   // controls follow the mode being registered, so both switch in the same cycle
   always_comb begin
      {nxt_pwr, nxt_t1k, nxt_t100k, nxt_hiz} = mode_onehot(nxt_mode); // RQ10 RQ11
      nxt_oe = nxt_pwr; // RQ12
   end

   // power-down only gates the output stage; the code register is left alone
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pwr_ff <= 1'b1;
         t1k_ff <= 1'b0;
         t100k_ff <= 1'b0;
         hiz_ff <= 1'b0;
         oe_ff <= 1'b1;
      end else begin
         pwr_ff <= nxt_pwr;
         t1k_ff <= nxt_t1k;
         t100k_ff <= nxt_t100k;
         hiz_ff <= nxt_hiz;
         oe_ff <= nxt_oe;
      end
   end

   assign code = code_ff;
   assign mode = mode_ff;
   assign powered = pwr_ff;
   assign term_1k = t1k_ff;
   assign term_100k = t100k_ff;
   assign out_hiz = hiz_ff;
   assign out_enable = oe_ff;
   assign update = upd_ff;
endmodule // dac_dev

// ===== hdl/dac_host.sv
// host end: buffers words and sends each as one sixteen-bit frame
`timescale 1ns/1ps
module dac_host #(
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic word_valid,
   output logic word_ready,
   input wire logic [15:0] word_data,
   output logic busy,
   dac_link_if.host link
);
   typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_GAP} host_st_e;
   host_st_e st_ff, nxt_st;
   logic [15:0] sh_ff, nxt_sh;
   logic [4:0] bit_ff, nxt_bit;
   logic [7:0] div_ff, nxt_div;
   logic fr_ff, nxt_fr, sck_ff, nxt_sck, dat_ff, nxt_dat, busy_ff, nxt_busy;
   logic f_valid, f_ready;
   logic [15:0] f_data;

   word_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(word_valid),
      .in_ready(word_ready),
      .in_data(word_data),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   // clock idles low, data changes on rising, device samples on falling
   always_comb begin
      nxt_st = st_ff;
      nxt_sh = sh_ff;
      nxt_bit = bit_ff;
      nxt_div = div_ff + 8'h01;
      nxt_fr = fr_ff;
      nxt_sck = sck_ff;
      nxt_dat = dat_ff;
      f_ready = 1'b0;
      case (st_ff)
         S_IDLE: begin
            nxt_div = 8'h00;
            if (f_valid) begin
               f_ready = 1'b1;
               nxt_sh = f_data;
               nxt_fr = 1'b0; // RQ1
               nxt_bit = 5'h00;
               nxt_st = S_LOW;
            end
         end
         S_LOW: begin
            if (div_ff == 8'(dac_link_pkg::SCLK_HALF_CYC - 1)) begin
               nxt_div = 8'h00;
               nxt_sck = 1'b1;
               nxt_dat = sh_ff[15]; // RQ5 RQ15 RQ16
               nxt_sh = {sh_ff[14:0], 1'b0};
               nxt_st = S_HIGH;
            end
         end
         S_HIGH: begin
            if (div_ff == 8'(dac_link_pkg::SCLK_HALF_CYC - 1)) begin
               nxt_div = 8'h00;
               nxt_sck = 1'b0;
               nxt_bit = bit_ff + 5'h01;
               nxt_st = (bit_ff == 5'(dac_link_pkg::FRAME_BITS - 1)) ? S_GAP : S_LOW; // RQ7
            end
         end
         default: begin
            // raise frame after sixteenth edge, idle data low, hold high gap
            nxt_fr = 1'b1; // RQ4
            nxt_dat = 1'b0; // RQ14
            if (div_ff == 8'(dac_link_pkg::SYNC_HIGH_CYC + dac_link_pkg::SCLK_HALF_CYC)) begin
               nxt_fr = 1'b0; // RQ14
               nxt_st = S_IDLE;
            end
         end
      endcase
      nxt_busy = nxt_st != S_IDLE || f_valid;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_ff <= S_IDLE;
         sh_ff <= 16'h0000;
         bit_ff <= 5'h00;
         div_ff <= 8'h00;
         fr_ff <= 1'b1;
         sck_ff <= 1'b0;
         dat_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         sh_ff <= nxt_sh;
         bit_ff <= nxt_bit;
         div_ff <= nxt_div;
         fr_ff <= nxt_fr;
         sck_ff <= nxt_sck;
         dat_ff <= nxt_dat;
         busy_ff <= nxt_busy;
      end
   end

   // frame line rests high from reset so the first word makes a real fall; idles low between frames
   assign link.frame_n = fr_ff;
   assign link.sclk = sck_ff;
   assign link.din = dat_ff;
   assign busy = busy_ff;
endmodule // dac_host

// ===== hdl/word_fifo.sv
// small valid/ready fifo holding host words
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   // pointer and count update; full stalls the writer
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      nxt_wr = push ? ((wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1) : wr_ff;
      nxt_rd = pop ? ((rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1) : rd_ff;
      nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   // storage has no reset, it is only read when valid
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ff] <= in_data;
      end
   end

   assign in_ready = cnt_ff != (AW+1)'(DEPTH);
   assign out_valid = cnt_ff != '0;
   assign out_data = mem[rd_ff];
endmodule // word_fifo

// ===== include/dac_link_if.sv
// three-wire write link between host and converter
`timescale 1ns/1ps
interface dac_link_if;
   logic frame_n;
   logic sclk;
   logic din;
   modport host (output frame_n, output sclk, output din);
   modport dev (input frame_n, input sclk, input din);
endinterface

// ===== include/dac_link_pkg.sv
// shared constants for the serial converter write link
package dac_link_pkg;
   localparam int FRAME_BITS = 16;
   localparam int CODE_BITS = 8;
   localparam int MODE_BITS = 2;
   localparam int MODE_HI_POS = 13;
   localparam int MODE_LO_POS = 12;
   localparam int CODE_MSB_POS = 11;
   localparam int CODE_LSB_POS = 4;
   localparam int BYTE_BITS = 8;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_PD_1K = 2'h1;
   localparam logic [1:0] MODE_PD_100K = 2'h2;
   localparam logic [1:0] MODE_PD_HIZ = 2'h3;
   localparam logic [7:0] CODE_RESET = 8'h00;
   localparam int SYS_CLK_NS = 40;
   localparam int SCLK_HALF_NS = 160;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int SYNC_HIGH_NS = 20;
   localparam int SYNC_HIGH_CYC = (SYNC_HIGH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
endpackage

// ===== verif/dac_link_sva.sv
// assertions on the write link and the device outputs
`timescale 1ns/1ps
module dac_link_sva (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic frame_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic [7:0] code,
   input wire logic [1:0] mode,
   input wire logic powered,
   input wire logic term_1k,
   input wire logic update
);
   logic [4:0] cnt_ff;
   logic [4:0] nxt_cnt;
   logic sclk_q_ff;
   logic frame_q_ff;
   // falling clock edges since the frame opened; saturates so late edges never wrap
   always_comb begin
      nxt_cnt = cnt_ff;
      if (frame_q_ff && !frame_n) begin
         nxt_cnt = 5'h00;
      end else if (sclk_q_ff && !sclk && !frame_n && cnt_ff != 5'h1F) begin
         nxt_cnt = cnt_ff + 5'h01;
      end
   end
   always_ff @(posedge sys_clk) begin
      cnt_ff <= rst_n ? nxt_cnt : 5'h00;
      sclk_q_ff <= rst_n ? sclk : 1'b0;
      frame_q_ff <= rst_n ? frame_n : 1'b0;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // the sixteenth falling edge inside an open frame
   sequence last_fall_s;
      cnt_ff == 5'h0F && sclk_q_ff && !sclk && !frame_n;
   endsequence
   chk_sclk_idle: assert property (frame_n |-> !sclk)
      else $error("serial clock active outside a frame");
   chk_din_on_fall: assert property ((sclk_q_ff && !sclk) |-> $stable(din))
      else $error("data moved at a falling clock edge");
   chk_frame_high: assert property ($rose(frame_n) |=> frame_n [*4])
      else $error("frame line high too briefly");
   chk_whole_frame: assert property ($rose(frame_n) |-> cnt_ff == 5'h10)
      else $error("frame closed without sixteen edges");
   chk_apply_latency: assert property (last_fall_s |-> ##[2:6] update)
      else $error("frame not applied after last edge");
   chk_update_count: assert property (update |-> cnt_ff == 5'h10)
      else $error("update without exactly sixteen edges");
   chk_update_pulse: assert property (update |=> !update)
      else $error("update longer than one cycle");
   chk_code_cause: assert property (($changed(code) || $changed(mode)) |-> update)
      else $error("code or mode changed without a frame");
   chk_power_decode: assert property (powered == (mode == dac_link_pkg::MODE_NORMAL))
      else $error("power state disagrees with mode");
   chk_term_decode: assert property (term_1k == (mode == dac_link_pkg::MODE_PD_1K))
      else $error("termination disagrees with mode");
endmodule // dac_link_sva

// ===== verif/serial_dac_write_and_mode_control_bench.sv
// self-checking bench: host and device joined across the write link
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module serial_dac_write_and_mode_control_bench;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic word_valid = 1'b0;
   logic [15:0] word_data = 16'h0000;
   logic word_ready, busy, powered, term_1k, term_100k, out_hiz, out_enable, update, update_b;
   logic [7:0] code, code_b;
   logic [1:0] mode, mode_b;
   int failures = 0;
   int checks = 0;
   int upd = 0;
   int upd_b = 0;
   dac_link_if lk ();
   dac_link_if lk_b ();
   dac_host u_dac_host (.sys_clk(sys_clk), .rst_n(rst_n), .word_valid(word_valid), .word_ready(word_ready),
      .word_data(word_data), .busy(busy), .link(lk.host));
   dac_dev u_dac_dev (.sys_clk(sys_clk), .rst_n(rst_n), .link(lk.dev), .code(code), .mode(mode), .powered(powered),
      .term_1k(term_1k), .term_100k(term_100k), .out_hiz(out_hiz), .out_enable(out_enable), .update(update));
   // second device driven by the bench to break the framing on purpose
   dac_dev u_dac_dev_b (.sys_clk(sys_clk), .rst_n(rst_n), .link(lk_b.dev), .code(code_b), .mode(mode_b), .powered(),
      .term_1k(), .term_100k(), .out_hiz(), .out_enable(), .update(update_b));
   dac_link_sva u_dac_link_sva (.sys_clk(sys_clk), .rst_n(rst_n), .frame_n(lk.frame_n), .sclk(lk.sclk),
      .din(lk.din), .code(code), .mode(mode), .powered(powered), .term_1k(term_1k), .update(update));
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   // count applied frames on each device
   always @(posedge sys_clk) begin
      upd <= upd + int'(update === 1'b1);
      upd_b <= upd_b + int'(update_b === 1'b1);
   end
   task stop_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task wait_upd(input int n);
      for (int k = 0; k < 4000 && upd < n; k++) @(negedge sys_clk);
      if (upd < n) begin
         failures++;
         stop_test;
      end
   endtask
   // holds valid up; the caller drops it a clock later
   task put_word(input logic [15:0] w);
      word_data = w;
      word_valid = 1'b1;
      for (int k = 0; k < 4000 && word_ready !== 1'b1; k++) @(negedge sys_clk);
      if (word_ready !== 1'b1) begin
         failures++;
         stop_test;
      end
      @(negedge sys_clk);
   endtask
   task check_out(input logic [1:0] m, input logic [7:0] c);
      `CHK(code, c)
      `CHK(mode, m)
      `CHK({term_1k, term_100k, out_hiz}, {m == 2'h1, m == 2'h2, m == 2'h3})
      `CHK({powered, out_enable}, {2{m == 2'h0}})
   endtask
   task t_modes;
      for (int i = 0; i < 5; i++) begin
         put_word({2'b11, i[1:0], 8'h5A, 4'hF});
         word_valid = 1'b0;
         wait_upd(upd + 1);
         check_out(i[1:0], 8'h5A);
      end
   endtask
   // back-to-back words fill the buffer while the link drains it slowly
   task t_fill;
      int base;
      logic full;
      base = upd;
      full = 1'b0;
      for (int i = 0; i < 12; i++) begin
         if (word_ready === 1'b0) full = 1'b1;
         put_word({4'h0, 8'hF4 + i[7:0], 4'h0});
      end
      word_valid = 1'b0;
      `CHK(full, 1'b1)
      wait_upd(base + 12);
      `CHK(code, 8'hFF)
      `CHK(upd - base, 12)
      for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge sys_clk);
      `CHK(busy, 1'b0)
   endtask
   task clock_bit(input logic b);
      lk_b.din = b;
      lk_b.sclk = 1'b1;
      repeat (4) @(negedge sys_clk);
      lk_b.sclk = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask
   task t_abort;
      logic [15:0] fw;
      fw = 16'h13C0;
      lk_b.frame_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      for (int i = 15; i > 5; i--) clock_bit(fw[i]);
      lk_b.frame_n = 1'b1;
      lk_b.din = 1'b0;
      repeat (8) @(negedge sys_clk);
      `CHK({mode_b, code_b}, 10'h000)
      `CHK(upd_b, 0)
      fw = 16'h2C35;
      lk_b.frame_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      // two bytes under one frame, with a pause between them, then surplus edges
      for (int i = 15; i >= 0; i--) begin
         clock_bit(fw[i]);
         if (i == 8) repeat (12) @(negedge sys_clk);
      end
      for (int i = 0; i < 16; i++) clock_bit(1'b1);
      `CHK({mode_b, code_b}, 10'h2C3)
      `CHK(upd_b, 1)
      lk_b.frame_n = 1'b1;
      lk_b.din = 1'b0;
   endtask
   initial begin
      lk_b.frame_n = 1'b1;
      lk_b.sclk = 1'b0;
      lk_b.din = 1'b0;
      repeat (8) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      check_out(2'h0, 8'h00);
      t_modes;
      t_fill;
      t_abort;
      stop_test;
   end
endmodule // serial_dac_write_and_mode_control_bench
